// >>> bench/eetb_chk_assertions.sv
// Purpose: Port checker for eetb_top
// Assumes: Bench limits of 80 cycles for self-timed program and erase runs
// Notes: Bound from the bench top file
`timescale 1ns/100ps
module eetb_chk #(
	parameter int P_PGM_LIMIT = 80,
	parameter int P_ERASE_LIMIT = 80
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_resetn,
	// Observed ports
	input wire logic [15:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] o_rdata,
	input wire logic [7:0] i_array_rdata,
	input wire logic [7:0] o_array_rdata,
	input wire logic o_array_read_block,
	input wire logic [1:0] o_hv_pulse
);
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_resetn);
	sequence s_rd(logic [15:0] a);
		i_rd && i_addr == a;
	endsequence
	sequence s_pgm;
		i_wr && i_addr == 16'hFE1D && i_wdata[4:0] == 5'h03 && !o_hv_pulse[0];
	endsequence
	sequence s_era;
		i_wr && i_addr == 16'hFF7D && i_wdata[1:0] == 2'h3 && i_wdata[4:3] != 2'h0
			&& !o_hv_pulse[1];
	endsequence
	property p_rd_idle;
		!i_rd |=> o_rdata == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
	property p_unmap;
		s_rd(16'hFE1C) |=> o_rdata == 8'h00;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	property p_opt;
		s_rd(16'hFE09) |=> o_rdata[3] && (o_rdata & 8'h67) == 8'h00;
	endproperty
	a_opt: assert property (p_opt) else $error("option read wrong");
	property p_cr7;
		i_rd && (i_addr == 16'hFE1D || i_addr == 16'hFF7D) |=> !o_rdata[7];
	endproperty
	a_cr7: assert property (p_cr7) else $error("control bit 7 set");
	property p_divh;
		i_rd && (i_addr == 16'hFE1A || i_addr == 16'hFF7A) |=> o_rdata[7:3] == 5'h00;
	endproperty
	a_divh: assert property (p_divh) else $error("divider high too wide");
	property p_block;
		o_array_read_block && $past(o_array_read_block) |-> o_array_rdata == 8'hFF;
	endproperty
	a_block: assert property (p_block) else $error("blocked read leaked");
	property p_pass;
		!o_array_read_block && !$past(o_array_read_block) && $past(i_resetn)
			|-> o_array_rdata == $past(i_array_rdata);
	endproperty
	a_pass: assert property (p_pass) else $error("array data not passed");
	property p_pgm;
		s_pgm |=> o_hv_pulse[0] ##[1:82] !o_hv_pulse[0];
	endproperty
	a_pgm: assert property (p_pgm) else $error("program run too long");
	property p_era;
		s_era |=> o_hv_pulse[1] ##[1:82] !o_hv_pulse[1];
	endproperty
	a_era: assert property (p_era) else $error("erase run too long");
endmodule

// >>> bench/test_eetb_top.sv
// Purpose: Self-checking bench for eetb_top
// Assumes: Short self-timed limits of 80 cycles for program and erase
// Notes: Read data checked by a monitor against queued expectations
`timescale 1ns/100ps
`include "eetb_params.svh"
module test_eetb_top;
	localparam int P_PGM_LIMIT = 80;
	// Discharge wait of 100 us at 10 MHz
	localparam int DISCHARGE_CYC = 1000;
	localparam int P_ERASE_LIMIT = 80;
	logic i_mclk, i_resetn, i_wr, i_rd, i_osc_tick, i_monitor_mode, rd_q;
	logic [15:0] i_addr;
	logic [7:0] i_wdata, i_array_rdata, i_nv_divh1, i_nv_divl1, i_nv_divh2, i_nv_divl2;
	logic [7:0] o_rdata, o_array_rdata, e, v;
	logic [7:0] exp_q[$];
	logic o_array_read_block, o_irq;
	logic [1:0] o_hv_pulse;
	int n_errors, samples_checked, k, t;
	eetb_top #(.P_PGM_LIMIT(P_PGM_LIMIT), .P_ERASE_LIMIT(P_ERASE_LIMIT)) i_dut (
		.i_mclk, .i_resetn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
		.i_osc_tick, .i_monitor_mode, .i_nv_divh1, .i_nv_divl1, .i_nv_divh2,
		.i_nv_divl2, .i_array_rdata, .o_array_rdata, .o_array_read_block,
		.o_hv_pulse, .o_irq
	);
	task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
		samples_checked++;
		if (g !== x) begin
			n_errors++;
			$display("BAD %s exp %h got %h", n, x, g);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		i_rd <= 1'b0;
		@(posedge i_mclk);
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] x);
		exp_q.push_back(x);
		i_addr <= a;
		i_rd <= 1'b1;
		i_wr <= 1'b0;
		@(posedge i_mclk);
	endtask
	task automatic idle(input int n);
		i_wr <= 1'b0;
		i_rd <= 1'b0;
		repeat (n) @(posedge i_mclk);
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		i_mclk = 1'b0;
		forever #50 i_mclk = ~i_mclk;
	end
	// Read data monitor
	always @(posedge i_mclk) begin
		if (rd_q === 1'b1) begin
			e = exp_q.pop_front();
			chk("rdata", e, o_rdata);
		end
		rd_q <= i_rd;
	end
	always @(posedge i_mclk) i_osc_tick <= 1'($urandom);
	initial begin
		t = $urandom(32'hB909);
		{i_resetn, i_wr, i_rd, i_monitor_mode} = 4'h0;
		i_addr = 16'h0000;
		i_wdata = 8'h00;
		i_array_rdata = 8'h00;
		{i_nv_divh1, i_nv_divl1, i_nv_divh2, i_nv_divl2} = $urandom;
		repeat (2) @(posedge i_mclk);
		i_resetn <= 1'b1;
		idle(2);
		rd(`EETB_ADR_OPT, `EETB_OPT_FIXED);
		rd(`EETB_ADR_DIVH1, i_nv_divh1 & `EETB_DIVH_WMASK);
		rd(`EETB_ADR_DIVL1, i_nv_divl1);
		rd(`EETB_ADR_DIVH2, i_nv_divh2 & `EETB_DIVH_WMASK);
		rd(`EETB_ADR_DIVL2, i_nv_divl2);
		wr(`EETB_ADR_OPT, 8'hFF);
		rd(`EETB_ADR_OPT, 8'h98);
		wr(`EETB_ADR_DIVH1, 8'hFF);
		wr(16'hFE1C, 8'h55);
		rd(16'hFE1C, 8'h00);
		rd(`EETB_ADR_DIVH1, 8'h07);
		v = 8'($urandom);
		wr(`EETB_ADR_DIVL2, v);
		rd(`EETB_ADR_DIVL2, v);
		wr(`EETB_ADR_CR1, 8'hE4);
		rd(`EETB_ADR_CR1, 8'h24);
		idle(2);
		i_resetn <= 1'b0;
		idle(2);
		i_resetn <= 1'b1;
		idle(2);
		rd(`EETB_ADR_DIVL2, i_nv_divl2);
		rd(`EETB_ADR_DIVH1, i_nv_divh1 & `EETB_DIVH_WMASK);
		wr(`EETB_ADR_DIVH1, 8'h07);
		wr(`EETB_ADR_OPT, 8'h90);
		wr(`EETB_ADR_MASK, 8'h01);
		for (k = 0; k < 2; k++) begin
			wr(k ? `EETB_ADR_CR2 : `EETB_ADR_CR1, k ? 8'h0B : 8'h03);
			wr(k ? `EETB_ADR_CR2 : `EETB_ADR_CR1, 8'h00);
			rd(k ? `EETB_ADR_CR2 : `EETB_ADR_CR1, k ? 8'h0B : 8'h03);
			idle(1);
			for (t = 0; t < 100 && o_hv_pulse[k] === 1'b1; t++) @(negedge i_mclk);
			if (t == 100) begin
				n_errors++;
				end_of_test();
			end
			chk("held", 8'h01, {7'h00, t > 20});
			@(posedge i_mclk);
			idle(DISCHARGE_CYC);
			rd(k ? `EETB_ADR_CR2 : `EETB_ADR_CR1, k ? 8'h0A : 8'h02);
			rd(`EETB_ADR_STAT, k ? 8'h02 : 8'h01);
			idle(1);
			@(negedge i_mclk);
			chk("irq", {7'h00, k == 0}, {7'h00, o_irq});
			@(posedge i_mclk);
			wr(`EETB_ADR_STAT, 8'h03);
			rd(`EETB_ADR_STAT, 8'h00);
			idle(3);
			@(negedge i_mclk);
			chk("irq", 8'h00, {7'h00, o_irq});
			@(posedge i_mclk);
		end
		// Divider zero on the bus clock: the optimum tick count ends before the ceiling
		wr(`EETB_ADR_DIVH1, 8'h00);
		wr(`EETB_ADR_DIVL1, 8'h00);
		wr(`EETB_ADR_OPT, 8'h10);
		wr(`EETB_ADR_CR1, 8'h03);
		idle(`EETB_PGM_TB_TICKS);
		@(negedge i_mclk);
		chk("tick_run", 8'h01, {6'h00, o_hv_pulse});
		@(posedge i_mclk);
		@(negedge i_mclk);
		chk("tick_end", 8'h00, {6'h00, o_hv_pulse});
		@(posedge i_mclk);
		wr(`EETB_ADR_STAT, 8'h03);
		idle(DISCHARGE_CYC);
		// Manual pulse kept short here; the block leaves its length to software
		wr(`EETB_ADR_CR1, 8'h01);
		idle(60);
		@(negedge i_mclk);
		chk("hv", 8'h01, {6'h00, o_hv_pulse});
		@(posedge i_mclk);
		wr(`EETB_ADR_CR1, 8'h00);
		i_monitor_mode <= 1'b1;
		i_array_rdata <= 8'($urandom);
		idle(3);
		@(negedge i_mclk);
		chk("hv", 8'h00, {6'h00, o_hv_pulse});
		chk("arr", 8'hFF, o_array_rdata);
		chk("blk", 8'h01, {7'h00, o_array_read_block});
		@(posedge i_mclk);
		i_monitor_mode <= 1'b0;
		idle(3);
		@(negedge i_mclk);
		chk("arr", i_array_rdata, o_array_rdata);
		@(posedge i_mclk);
		idle(2);
		end_of_test();
	end
endmodule
bind eetb_top eetb_chk #(.P_PGM_LIMIT(P_PGM_LIMIT), .P_ERASE_LIMIT(P_ERASE_LIMIT)) u_chk (
	.i_mclk, .i_resetn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
	.i_array_rdata, .o_array_rdata, .o_array_read_block, .o_hv_pulse
);

// >>> rtl/eetb_params.svh
// Purpose: Constants of the EEPROM time base and self-timed program block
// Assumes: 10 MHz bus clock, byte-wide register port on a 16-bit address
// Notes: Time limits are kept in their own units and converted below
`ifndef EETB_PARAMS_SVH
`define EETB_PARAMS_SVH

`define EETB_CLK_MHZ 10
`define EETB_US_PER_MS 1000
`define EETB_PGM_MAX_US 500
`define EETB_ERASE_MAX_MS 8
`define EETB_PGM_LIMIT_CYC (`EETB_PGM_MAX_US * `EETB_CLK_MHZ)
`define EETB_ERASE_LIMIT_CYC (`EETB_ERASE_MAX_MS * `EETB_US_PER_MS * `EETB_CLK_MHZ)
`define EETB_LIMIT_SLACK 2

// Optimum pulse lengths in time base ticks
`define EETB_PGM_TB_TICKS 8'h32
`define EETB_ERASE_TB_TICKS 8'hC8

// Register addresses
`define EETB_ADR_OPT 16'hFE09
`define EETB_ADR_NVDIVH1 16'hFE10
`define EETB_ADR_NVDIVL1 16'hFE11
`define EETB_ADR_DIVH1 16'hFE1A
`define EETB_ADR_DIVL1 16'hFE1B
`define EETB_ADR_CR1 16'hFE1D
`define EETB_ADR_STAT 16'hFE1E
`define EETB_ADR_NVDIVH2 16'hFF70
`define EETB_ADR_NVDIVL2 16'hFF71
`define EETB_ADR_DIVH2 16'hFF7A
`define EETB_ADR_DIVL2 16'hFF7B
`define EETB_ADR_CR2 16'hFF7D
`define EETB_ADR_MASK 16'hFF7E

// Field positions and masks
`define EETB_OPT_CLKSEL 7
`define EETB_OPT_RDPROT 4
`define EETB_OPT_WMASK 8'h90
`define EETB_OPT_FIXED 8'h08
`define EETB_CR_ERAS_HI 4
`define EETB_CR_ERAS_LO 3
`define EETB_CR_AUTO 1
`define EETB_CR_PGM 0
`define EETB_CR_WMASK 8'h3F
`define EETB_DIVH_WMASK 8'h07
`define EETB_DIVH_MSB 2
`define EETB_EV_DONE1 0
`define EETB_EV_DONE2 1
`define EETB_EV_WMASK 8'h03
`define EETB_ERASED_BYTE 8'hFF
`define EETB_ZERO_BYTE 8'h00

`endif

// >>> rtl/eetb_pkg.sv
// Purpose: Types shared by the EEPROM time base block
// Assumes: Nothing beyond the constants header
// Notes: States use Gray codes along the run path
package eetb_pkg;
	typedef enum logic [1:0] {
		EETB_IDLE = 2'b00,
		EETB_RUN = 2'b01
	} eetb_state_t;

	typedef struct packed {
		eetb_state_t state;
		logic [10:0] presc;
		logic [7:0] ticks;
		logic [16:0] cyc;
		logic erase;
		logic busy;
		logic done;
	} eetb_tmr_t;

	typedef struct packed {
		logic [7:0] opt;
		logic [7:0] divh1;
		logic [7:0] divl1;
		logic [7:0] divh2;
		logic [7:0] divl2;
		logic [7:0] cr1;
		logic [7:0] cr2;
		logic [7:0] stat;
		logic [7:0] mask;
		logic [7:0] rdata;
		logic [7:0] ardata;
		logic rdblk;
		logic load;
		logic irq;
		logic [1:0] pulse;
	} eetb_regs_t;
endpackage

// >>> rtl/eetb_timer.sv
// Purpose: Time base prescaler and self-timed pulse counter for one array
// Assumes: i_ref_tick marks one period of the selected reference clock
// Notes: Ends on the optimum tick count or on the cycle ceiling, whichever first
`timescale 1ns/100ps
`include "eetb_params.svh"
module eetb_timer #(
	parameter int P_PGM_LIMIT = `EETB_PGM_LIMIT_CYC,
	parameter int P_ERASE_LIMIT = `EETB_ERASE_LIMIT_CYC
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_resetn,
	// Time base
	input wire logic i_ref_tick,
	input wire logic [10:0] i_div,
	// Operation
	input wire logic i_start,
	input wire logic i_erase,
	output logic o_busy,
	output logic o_done
);
	import eetb_pkg::*;

	eetb_tmr_t s;
	eetb_tmr_t next_s;
	logic tb;
	logic [7:0] target;
	logic [16:0] limit;

	always_comb begin
		next_s = s;
		next_s.done = 1'b0;
		tb = 1'b0;
		target = s.erase ? `EETB_ERASE_TB_TICKS : `EETB_PGM_TB_TICKS;
		limit = s.erase ? 17'(P_ERASE_LIMIT - `EETB_LIMIT_SLACK)
			: 17'(P_PGM_LIMIT - `EETB_LIMIT_SLACK);
		case (s.state)
			EETB_IDLE: begin
				if (i_start) begin
					next_s.state = EETB_RUN;
					next_s.presc = 11'h000;
					next_s.ticks = 8'h00;
					next_s.cyc = 17'h00000;
					next_s.erase = i_erase;
					next_s.busy = 1'b1;
				end
			end
			EETB_RUN: begin
				next_s.cyc = s.cyc + 17'h00001;
				// Divide the reference by the 11-bit value plus one
				if (i_ref_tick) begin
					if (s.presc >= i_div) begin
						next_s.presc = 11'h000;
						next_s.ticks = s.ticks + 8'h01;
						tb = 1'b1;
					end else begin
						next_s.presc = s.presc + 11'h001;
					end
				end
				// Ceiling keeps completion inside the guaranteed time
				if ((tb && next_s.ticks >= target) || s.cyc >= limit) begin
					next_s.state = EETB_IDLE;
					next_s.busy = 1'b0;
					next_s.done = 1'b1;
				end
			end
			default: begin
				next_s.state = EETB_IDLE;
				next_s.busy = 1'b0;
			end
		endcase
	end

	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign o_busy = s.busy;
	assign o_done = s.done;
endmodule

// >>> rtl/eetb_top.sv
// Purpose: EEPROM time base, self-timed program/erase and option register
// Assumes: Byte register port, read data one cycle after the read strobe
// Notes: Non-volatile divider copies arrive as inputs from the NVM rows
`timescale 1ns/100ps
`include "eetb_params.svh"
module eetb_top #(
	parameter int P_PGM_LIMIT = `EETB_PGM_LIMIT_CYC,
	parameter int P_ERASE_LIMIT = `EETB_ERASE_LIMIT_CYC
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_resetn,
	// Register port
	input wire logic [15:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	// Reference clock and mode
	input wire logic i_osc_tick,
	input wire logic i_monitor_mode,
	// Non-volatile divider copies
	input wire logic [7:0] i_nv_divh1,
	input wire logic [7:0] i_nv_divl1,
	input wire logic [7:0] i_nv_divh2,
	input wire logic [7:0] i_nv_divl2,
	// Array read path
	input wire logic [7:0] i_array_rdata,
	output logic [7:0] o_array_rdata,
	output logic o_array_read_block,
	// High-voltage pulse per array and interrupt
	output logic [1:0] o_hv_pulse,
	output logic o_irq
);
	import eetb_pkg::*;

	eetb_regs_t r;
	eetb_regs_t next_r;
	logic ref_tick;
	logic start1;
	logic start2;
	logic busy1;
	logic busy2;
	logic done1;
	logic done2;
	logic [7:0] evt;
	logic [7:0] clr;

	function automatic logic wr_at(input logic wr, input logic [15:0] a,
		input logic [15:0] target);
		wr_at = wr && (a == target);
	endfunction

	// Control register update for one array
	function automatic logic [7:0] cr_next(input logic [7:0] cur, input logic we,
		input logic [7:0] wd, input logic busy, input logic done);
		logic [7:0] v;
		v = cur;
		if (we) begin
			v = wd & `EETB_CR_WMASK;
		end
		if (busy) begin
			v[`EETB_CR_PGM] = 1'b1;
			v[`EETB_CR_AUTO] = cur[`EETB_CR_AUTO];
			v[`EETB_CR_ERAS_HI] = cur[`EETB_CR_ERAS_HI];
			v[`EETB_CR_ERAS_LO] = cur[`EETB_CR_ERAS_LO];
		end
		if (done) begin
			v[`EETB_CR_PGM] = 1'b0;
		end
		return v;
	endfunction

	function automatic logic starts(input logic [7:0] cur, input logic [7:0] nxt);
		starts = nxt[`EETB_CR_PGM] && !cur[`EETB_CR_PGM] && nxt[`EETB_CR_AUTO];
	endfunction

	function automatic logic is_erase(input logic [7:0] cr);
		is_erase = cr[`EETB_CR_ERAS_HI] || cr[`EETB_CR_ERAS_LO];
	endfunction

	// Reference select from the option register
	assign ref_tick = r.opt[`EETB_OPT_CLKSEL] ? i_osc_tick : 1'b1;
	assign start1 = starts(r.cr1, next_r.cr1);
	assign start2 = starts(r.cr2, next_r.cr2);

	always_comb begin
		next_r = r;
		evt = `EETB_ZERO_BYTE;
		evt[`EETB_EV_DONE1] = done1;
		evt[`EETB_EV_DONE2] = done2;
		clr = wr_at(i_wr, i_addr, `EETB_ADR_STAT) ? i_wdata : `EETB_ZERO_BYTE;

		// Volatile dividers reload from the non-volatile copies after reset
		if (r.load) begin
			next_r.load = 1'b0;
			next_r.divh1 = i_nv_divh1 & `EETB_DIVH_WMASK;
			next_r.divl1 = i_nv_divl1;
			next_r.divh2 = i_nv_divh2 & `EETB_DIVH_WMASK;
			next_r.divl2 = i_nv_divl2;
		end else begin
			if (wr_at(i_wr, i_addr, `EETB_ADR_DIVH1)) begin
				next_r.divh1 = i_wdata & `EETB_DIVH_WMASK;
			end
			if (wr_at(i_wr, i_addr, `EETB_ADR_DIVL1)) begin
				next_r.divl1 = i_wdata;
			end
			if (wr_at(i_wr, i_addr, `EETB_ADR_DIVH2)) begin
				next_r.divh2 = i_wdata & `EETB_DIVH_WMASK;
			end
			if (wr_at(i_wr, i_addr, `EETB_ADR_DIVL2)) begin
				next_r.divl2 = i_wdata;
			end
		end

		// Only the clock select and read protect bits are writable
		if (wr_at(i_wr, i_addr, `EETB_ADR_OPT)) begin
			next_r.opt = (i_wdata & `EETB_OPT_WMASK) | `EETB_OPT_FIXED;
		end

		// Control registers
		next_r.cr1 = cr_next(r.cr1, wr_at(i_wr, i_addr, `EETB_ADR_CR1), i_wdata,
			busy1, done1);
		next_r.cr2 = cr_next(r.cr2, wr_at(i_wr, i_addr, `EETB_ADR_CR2), i_wdata,
			busy2, done2);

		// Manual mode pulse follows program enable; length is software's job
		next_r.pulse[0] = next_r.cr1[`EETB_CR_PGM];
		next_r.pulse[1] = next_r.cr2[`EETB_CR_PGM];

		// Completion flags: set wins over the write-one clear
		next_r.stat = ((r.stat & ~clr) | evt) & `EETB_EV_WMASK;
		if (wr_at(i_wr, i_addr, `EETB_ADR_MASK)) begin
			next_r.mask = i_wdata & `EETB_EV_WMASK;
		end
		next_r.irq = |(next_r.stat & next_r.mask);

		// Register read, answer in the following cycle
		next_r.rdata = `EETB_ZERO_BYTE;
		if (i_rd) begin
			case (i_addr)
				`EETB_ADR_OPT: next_r.rdata = r.opt;
				`EETB_ADR_NVDIVH1: next_r.rdata = i_nv_divh1;
				`EETB_ADR_NVDIVL1: next_r.rdata = i_nv_divl1;
				`EETB_ADR_DIVH1: next_r.rdata = r.divh1;
				`EETB_ADR_DIVL1: next_r.rdata = r.divl1;
				`EETB_ADR_CR1: next_r.rdata = r.cr1;
				`EETB_ADR_STAT: next_r.rdata = r.stat;
				`EETB_ADR_NVDIVH2: next_r.rdata = i_nv_divh2;
				`EETB_ADR_NVDIVL2: next_r.rdata = i_nv_divl2;
				`EETB_ADR_DIVH2: next_r.rdata = r.divh2;
				`EETB_ADR_DIVL2: next_r.rdata = r.divl2;
				`EETB_ADR_CR2: next_r.rdata = r.cr2;
				`EETB_ADR_MASK: next_r.rdata = r.mask;
				default: next_r.rdata = `EETB_ZERO_BYTE;
			endcase
		end

		// Monitor mode read protection
		next_r.rdblk = r.opt[`EETB_OPT_RDPROT] && i_monitor_mode;
		// Blocked reads look erased
		next_r.ardata = next_r.rdblk ? `EETB_ERASED_BYTE : i_array_rdata;
	end

	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			r <= '0;
			r.opt <= `EETB_OPT_FIXED;
			r.load <= 1'b1;
			r.ardata <= `EETB_ERASED_BYTE;
		end else begin
			r <= next_r;
		end
	end

	eetb_timer #(
		.P_PGM_LIMIT(P_PGM_LIMIT),
		.P_ERASE_LIMIT(P_ERASE_LIMIT)
	) u_tmr1 (
		.i_mclk(i_mclk),
		.i_resetn(i_resetn),
		.i_ref_tick(ref_tick),
		.i_div({r.divh1[`EETB_DIVH_MSB:0], r.divl1}),
		.i_start(start1),
		.i_erase(is_erase(next_r.cr1)),
		.o_busy(busy1),
		.o_done(done1)
	);

	eetb_timer #(
		.P_PGM_LIMIT(P_PGM_LIMIT),
		.P_ERASE_LIMIT(P_ERASE_LIMIT)
	) u_tmr2 (
		.i_mclk(i_mclk),
		.i_resetn(i_resetn),
		.i_ref_tick(ref_tick),
		.i_div({r.divh2[`EETB_DIVH_MSB:0], r.divl2}),
		.i_start(start2),
		.i_erase(is_erase(next_r.cr2)),
		.o_busy(busy2),
		.o_done(done2)
	);

	assign o_rdata = r.rdata;
	assign o_array_rdata = r.ardata;
	assign o_array_read_block = r.rdblk;
	assign o_hv_pulse = r.pulse;
	assign o_irq = r.irq;
endmodule
